//--- hdl/rri_interlock.sv
// Purpose: reset/restart interlock that grants a release after guards and operator reset
// Assumes: guard and button pins are asynchronous; scans are paced by a divider enable
// Notes: the restart flavour is this same module; control and status sit on AXI4-Lite
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module rri_interlock #(
	parameter int unsigned SCAN_CYCLES = rri_pkg::SCAN_CYCLES,
	parameter int unsigned HOLD_SCANS = rri_pkg::HOLD_SCANS,
	parameter int unsigned FLASH_HALF_SCANS = rri_pkg::FLASH_HALF_SCANS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// field pins
	input wire logic [7:0] guard_in,
	input wire logic reset_btn,
	output logic release_out,
	output logic healthy_out,
	output logic pending_out,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// two-flop synchronisers for the pins
	logic [8:0] sync1_q; // first stage, read only by the second
	logic [8:0] sync2_q; // usable pin levels
	logic [7:0] guard_s;
	logic btn_s;

	// bus state
	logic aw_full_q, aw_full_d; // write address held
	logic [7:0] aw_addr_q, aw_addr_d;
	logic w_full_q, w_full_d; // write data held
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	rri_pkg::rri_ctrl_t ctrl_q, ctrl_d; // software control

	// interlock state
	logic [rri_pkg::SCAN_CNT_W-1:0] scan_cnt_q, scan_cnt_d; // scan divider
	logic tick; // one-cycle scan enable
	logic prev_run_q, prev_run_d; // run level seen last cycle
	logic armed_q, armed_d; // button seen off while guards on
	logic holding_q, holding_d; // button held after arming
	logic [rri_pkg::TMR_W-1:0] hold_cnt_q, hold_cnt_d; // scans button held
	logic [rri_pkg::TMR_W-1:0] flash_cnt_q, flash_cnt_d; // scans in this flash phase
	logic flash_ph_q, flash_ph_d; // flash phase level
	rri_pkg::rri_outs_t outs_q, outs_d; // registered pin outputs
	logic all_on; // all enabled guards on
	logic [7:0] guard_mask;

	// mask of enabled guards from the configured count
	function automatic logic [7:0] mask_of(input logic [3:0] n);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < n) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	// clamp a written guard count into the legal span
	function automatic logic [3:0] clamp_num(input logic [3:0] n);
		if (n < rri_pkg::NUM_IN_MIN) begin
			return rri_pkg::NUM_IN_MIN;
		end else if (n > rri_pkg::NUM_IN_MAX) begin
			return rri_pkg::NUM_IN_MAX;
		end
		return n;
	endfunction

	// pin synchronisers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sync1_q <= 9'h000;
			sync2_q <= 9'h000;
		end else begin
			sync1_q <= {reset_btn, guard_in};
			sync2_q <= sync1_q;
		end
	end
	assign guard_s = sync2_q[7:0];
	assign btn_s = sync2_q[8];

	// guard evaluation: primary is bit 0, extras above it
	assign guard_mask = mask_of(ctrl_q.num_in);
	assign all_on = ((guard_s & guard_mask) == guard_mask);
	assign tick = ctrl_q.run && (scan_cnt_q == rri_pkg::SCAN_CNT_W'(SCAN_CYCLES - 1));

	// next state of the bus slave and control register
	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d = w_full_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		ctrl_d = ctrl_q;
		// accept address and data in either order
		if (s_axi_awvalid && !aw_full_q) begin
			aw_full_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_full_q) begin
			w_full_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		// retire the response once taken
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// both halves held and no response pending: perform the write
		if (aw_full_q && w_full_q && !bvalid_q) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			if (aw_addr_q[7:2] == rri_pkg::OFF_CTRL[7:2]) begin
				bresp_d = rri_pkg::RESP_OKAY;
				if (w_strb_q[0]) begin
					// only the low byte carries fields
					ctrl_d = rri_pkg::rri_ctrl_t'(w_data_q[7:0]);
					ctrl_d.num_in = clamp_num(w_data_q[rri_pkg::CTRL_NUM_LSB +: 4]);
				end
			end else if (aw_addr_q[7:2] == rri_pkg::OFF_STATUS[7:2]) begin
				bresp_d = rri_pkg::RESP_OKAY; // read-only, write ignored
			end else begin
				bresp_d = rri_pkg::RESP_SLVERR; // unmapped
			end
		end
		// read: retire then accept a new address
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rdata_d = 32'h0000_0000;
			rresp_d = rri_pkg::RESP_OKAY;
			if (s_axi_araddr[7:2] == rri_pkg::OFF_CTRL[7:2]) begin
				rdata_d[7:0] = ctrl_q;
			end else if (s_axi_araddr[7:2] == rri_pkg::OFF_STATUS[7:2]) begin
				rdata_d[rri_pkg::STAT_RELEASE_BIT] = outs_q.release_out;
				rdata_d[rri_pkg::STAT_HEALTHY_BIT] = all_on;
				rdata_d[rri_pkg::STAT_PENDING_BIT] = outs_q.pending;
				rdata_d[rri_pkg::STAT_ARMED_BIT] = armed_q;
				rdata_d[rri_pkg::STAT_BTN_BIT] = btn_s;
				rdata_d[rri_pkg::STAT_GUARD_LSB +: 8] = guard_s;
			end else begin
				rresp_d = rri_pkg::RESP_SLVERR; // unmapped
			end
		end
	end

	// bus slave registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
			ctrl_q <= '{num_in: rri_pkg::NUM_IN_RESET, en_pend: 1'b1, en_heal: 1'b1,
				edge_mode: 1'b0, run: 1'b0};
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q <= w_full_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			ctrl_q <= ctrl_d;
		end
	end

	// next state of the interlock, stepped once per scan
	always_comb begin
		scan_cnt_d = scan_cnt_q;
		prev_run_d = ctrl_q.run;
		armed_d = armed_q;
		holding_d = holding_q;
		hold_cnt_d = hold_cnt_q;
		flash_cnt_d = flash_cnt_q;
		flash_ph_d = flash_ph_q;
		outs_d = outs_q;
		if (!ctrl_q.run || !prev_run_q) begin
			// stopped or first cycle of operation: everything cleared except the flash phase, which is set
			scan_cnt_d = '0;
			armed_d = 1'b0;
			holding_d = 1'b0;
			hold_cnt_d = '0;
			flash_cnt_d = '0;
			flash_ph_d = 1'b1;
			outs_d = '0;
		end else begin
			scan_cnt_d = tick ? '0 : scan_cnt_q + 1'b1;
			if (tick) begin
				outs_d.healthy = all_on && ctrl_q.en_heal;
				if (!all_on) begin
					// a guard dropped: lose release and any arming
					outs_d.release_out = 1'b0;
					armed_d = 1'b0;
					holding_d = 1'b0;
					hold_cnt_d = '0;
				end else if (!outs_q.release_out) begin
					if (!armed_q) begin
						// arm only on a scan where the button is off
						armed_d = !btn_s;
					end else if (ctrl_q.edge_mode) begin
						// off in an armed scan, now on: a rising edge
						if (btn_s) begin
							outs_d.release_out = 1'b1;
							armed_d = 1'b0;
						end
					end else if (btn_s) begin
						// held-pulse: count scans the button stays on
						holding_d = 1'b1;
						if (hold_cnt_q != {rri_pkg::TMR_W{1'b1}}) begin
							hold_cnt_d = hold_cnt_q + 1'b1;
						end
					end else if (holding_q) begin
						// falling edge: accept only after the full hold
						holding_d = 1'b0;
						hold_cnt_d = '0;
						if (hold_cnt_q >= rri_pkg::TMR_W'(HOLD_SCANS)) begin
							outs_d.release_out = 1'b1;
							armed_d = 1'b0;
						end
					end
				end
				// flash timer runs only while waiting for reset
				if (all_on && !outs_d.release_out) begin
					if (flash_cnt_q == rri_pkg::TMR_W'(FLASH_HALF_SCANS - 1)) begin
						flash_cnt_d = '0;
						flash_ph_d = !flash_ph_q;
					end else begin
						flash_cnt_d = flash_cnt_q + 1'b1;
					end
				end else begin
					flash_cnt_d = '0;
					flash_ph_d = 1'b1;
				end
				// pending: steady while held in held-pulse mode, else the flash
				if (!ctrl_q.en_pend || !all_on || outs_d.release_out) begin
					outs_d.pending = 1'b0;
				end else if (!ctrl_q.edge_mode && holding_d) begin
					outs_d.pending = 1'b1;
				end else begin
					outs_d.pending = flash_ph_d;
				end
			end
		end
	end

	// interlock registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			scan_cnt_q <= '0;
			prev_run_q <= 1'b0;
			armed_q <= 1'b0;
			holding_q <= 1'b0;
			hold_cnt_q <= '0;
			flash_cnt_q <= '0;
			flash_ph_q <= 1'b1;
			outs_q <= '0;
		end else begin
			scan_cnt_q <= scan_cnt_d;
			prev_run_q <= prev_run_d;
			armed_q <= armed_d;
			holding_q <= holding_d;
			hold_cnt_q <= hold_cnt_d;
			flash_cnt_q <= flash_cnt_d;
			flash_ph_q <= flash_ph_d;
			outs_q <= outs_d;
		end
	end

	// outputs straight from flip-flops; restart use needs no other logic
	assign release_out = outs_q.release_out;
	assign healthy_out = outs_q.healthy;
	assign pending_out = outs_q.pending;
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule // rri_interlock

//--- shared/rri_pkg.sv
// Purpose: constants and types shared by the reset/restart interlock
// Assumes: core clock at 100 MHz, register bus is AXI4-Lite with 32-bit data
// Notes: times are kept in their own units and turned into counts here
package rri_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;

	// control field layout and reset values
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_EDGE_BIT = 1;
	localparam int CTRL_EN_HEAL_BIT = 2;
	localparam int CTRL_EN_PEND_BIT = 3;
	localparam int CTRL_NUM_LSB = 4;
	localparam logic [3:0] NUM_IN_MIN = 4'h2;
	localparam logic [3:0] NUM_IN_MAX = 4'h8;
	localparam logic [3:0] NUM_IN_RESET = 4'h2;

	// status field layout
	localparam int STAT_RELEASE_BIT = 0;
	localparam int STAT_HEALTHY_BIT = 1;
	localparam int STAT_PENDING_BIT = 2;
	localparam int STAT_ARMED_BIT = 3;
	localparam int STAT_BTN_BIT = 4;
	localparam int STAT_GUARD_LSB = 8;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// timing: clock, scan period, reset hold time, flash rate
	localparam int CLK_MHZ = 100;
	localparam int SCAN_TIME_US = 1000;
	localparam int SCAN_CYCLES = SCAN_TIME_US * CLK_MHZ;
	localparam int HOLD_TIME_MS = 350;
	localparam int HOLD_SCANS = (HOLD_TIME_MS * 1000 + SCAN_TIME_US - 1) / SCAN_TIME_US;
	localparam int FLASH_HZ = 1;
	localparam int FLASH_HALF_SCANS = 1000000 / (2 * FLASH_HZ * SCAN_TIME_US);
	localparam int SCAN_CNT_W = 17;
	localparam int TMR_W = 16;

	// control register as software sees it
	typedef struct packed {
		logic [3:0] num_in;
		logic en_pend;
		logic en_heal;
		logic edge_mode;
		logic run;
	} rri_ctrl_t;

	// interlock outputs travelling together
	typedef struct packed {
		logic release_out;
		logic healthy;
		logic pending;
	} rri_outs_t;

endpackage

//--- tb/rri_checker.sv
// Purpose: property checks on interlock pins and register bus
// Assumes: scans come every SCAN_CYCLES core cycles
// Notes: guard bits 1:0 are enabled for every count
`timescale 1ns/100ps
module rri_checker #(
	parameter int unsigned SCAN_CYCLES = 10
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// field pins
	input wire logic [7:0] guard_in,
	input wire logic release_out,
	input wire logic healthy_out,
	input wire logic pending_out,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [6:0] off_q; // cycles a fixed guard has been off
	logic [6:0] off_d;
	// saturating count, cleared while both fixed guards are on
	always_comb begin
		off_d = (&guard_in[1:0]) ? 7'h00 : off_q + {6'h00, ~&off_q};
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			off_q <= 7'h00;
		end else begin
			off_q <= off_d;
		end
	end
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// sync, one scan and the output edge are the worst latency
	a_release_guard_off: assert property (off_q > SCAN_CYCLES + 3 |-> !release_out)
		else $error("release while a guard is off");
	a_healthy_guard_off: assert property (off_q > SCAN_CYCLES + 3 |-> !healthy_out)
		else $error("healthy while a guard is off");
	a_pending_guard_off: assert property (off_q > SCAN_CYCLES + 3 |-> !pending_out)
		else $error("pending while a guard is off");
	a_pending_not_released: assert property (release_out |-> !pending_out)
		else $error("pending while released");
	a_release_per_scan: assert property ($changed(release_out) |=> $stable(release_out) [*8])
		else $error("release moved twice in one scan");
	// both halves are held one edge, the write lands the next, so the answer stands two edges on
	a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_write_answer_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_read_answer_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule // rri_checker

bind rri_interlock rri_checker #(.SCAN_CYCLES(SCAN_CYCLES)) u_rri_checker (.core_clk(core_clk), .reset(reset),
	.guard_in(guard_in), .release_out(release_out), .healthy_out(healthy_out), .pending_out(pending_out),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- tb/rri_field_model.sv
// Purpose: operator button and guard devices in front of the interlock
// Assumes: commands change just after a clock edge
// Notes: pins are always driven, never released
`timescale 1ns/100ps
module rri_field_model (
	// clock
	input wire logic core_clk,
	// commands from the bench
	input wire logic [7:0] g_cmd,
	input wire logic b_cmd,
	// pins toward the block
	output logic [7:0] guard_in,
	output logic reset_btn
);
	// the bench times holds and edges, the model only drives the contacts
	always_ff @(posedge core_clk) begin
		guard_in <= g_cmd;
		reset_btn <= b_cmd;
	end
endmodule // rri_field_model

//--- tb/rri_interlock_tb_top.sv
// Purpose: register and pin sequences for the interlock
// Assumes: shortened scan 10, hold 3 scans, flash half period 2 scans
// Notes: waits are whole scans so tick phase does not matter
`timescale 1ns/100ps
module rri_interlock_tb_top;
	localparam int SC = 10;
	logic core_clk, reset, b_cmd, reset_btn, release_out, healthy_out, pending_out;
	logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, p0, p1, st;
	logic [7:0] g_cmd, guard_in, aw_a, ar_a;
	logic [31:0] w_d, r_d, d;
	logic [1:0] b_s, r_s, s;
	int mismatches, tests_run, cyc, i;
	rri_field_model u_rri_field_model (.core_clk(core_clk), .g_cmd(g_cmd), .b_cmd(b_cmd),
		.guard_in(guard_in), .reset_btn(reset_btn));
	rri_interlock #(.SCAN_CYCLES(SC), .HOLD_SCANS(3), .FLASH_HALF_SCANS(2)) u_rri_interlock (
		.core_clk(core_clk), .reset(reset), .guard_in(guard_in), .reset_btn(reset_btn),
		.release_out(release_out), .healthy_out(healthy_out), .pending_out(pending_out),
		.s_axi_awaddr(aw_a), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
		.s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
		.s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// bus write, response code left in s
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		aw_a <= a;
		w_d <= v;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		do begin
			@(posedge core_clk);
			if (aw_r) aw_v <= 1'b0;
			if (w_r) w_v <= 1'b0;
		end while (!b_v);
		s = b_s;
		b_r <= 1'b0;
	endtask
	// bus read, data in d and response in s
	task rd(input logic [7:0] a);
		@(posedge core_clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do begin
			@(posedge core_clk);
			if (ar_r) ar_v <= 1'b0;
		end while (!r_v);
		d = r_d;
		s = r_s;
		r_r <= 1'b0;
	endtask
	task sc(input int n);
		repeat (n * SC) @(posedge core_clk);
	endtask
	// hold the button n scans, then let go and settle
	task press(input int n);
		b_cmd <= 1'b1;
		sc(n);
		b_cmd <= 1'b0;
		sc(3);
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			mismatches++;
			print_verdict;
		end
	end
	initial begin
		{reset, aw_v, w_v, b_r, ar_v, r_r, b_cmd} = 7'h40;
		{aw_a, ar_a, g_cmd, w_d} = '0;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		// registers: reset value, unmapped, read-only, clamping
		rd(8'h00);
		chk(d, 32'h2c);
		rd(8'h08);
		chk(s, rri_pkg::RESP_SLVERR);
		wr(8'h04, 32'hff);
		chk(s, rri_pkg::RESP_OKAY);
		rd(8'h04);
		chk(d, 32'h0);
		wr(8'h00, 32'hfd);
		rd(8'h00);
		chk(d, 32'h8d);
		wr(8'h00, 32'h1d);
		rd(8'h00);
		chk(d, 32'h2d);
		$display("test registers done");
		// held-pulse: flash, short press, long press
		g_cmd <= 8'h03;
		sc(3);
		chk(healthy_out, 1);
		{p0, p1} = 2'b00;
		for (i = 0; i < 6; i++) begin
			sc(1);
			p1 |= pending_out;
			p0 |= !pending_out;
		end
		chk({p0, p1}, 2'b11);
		press(2);
		chk(release_out, 0);
		b_cmd <= 1'b1;
		sc(2);
		st = 1'b1;
		for (i = 0; i < 4; i++) begin
			sc(1);
			st &= pending_out;
		end
		chk(st, 1);
		b_cmd <= 1'b0;
		sc(3);
		chk({release_out, pending_out}, 2'b10);
		g_cmd <= 8'h01;
		sc(3);
		chk({release_out, healthy_out}, 2'b00);
		b_cmd <= 1'b1;
		g_cmd <= 8'h03;
		sc(6);
		b_cmd <= 1'b0;
		sc(3);
		chk(release_out, 0);
		press(6);
		chk(release_out, 1);
		// status word: released, guards on, no pending, disarmed, button off, guards 0x03
		rd(8'h04);
		chk(d, 32'h0000_0303);
		$display("test held done");
		// edge confirmation
		wr(8'h00, 32'h2f);
		g_cmd <= 8'h00;
		sc(3);
		g_cmd <= 8'h03;
		sc(3);
		b_cmd <= 1'b1;
		sc(3);
		chk(release_out, 1);
		b_cmd <= 1'b0;
		g_cmd <= 8'h00;
		sc(3);
		b_cmd <= 1'b1;
		sc(1);
		g_cmd <= 8'h03;
		sc(4);
		chk(release_out, 0);
		b_cmd <= 1'b0;
		$display("test edge done");
		// eight guards, optional outputs, start of operation
		wr(8'h00, 32'h8d);
		g_cmd <= 8'h7f;
		sc(3);
		chk({release_out, healthy_out}, 2'b00);
		g_cmd <= 8'hff;
		sc(3);
		chk(healthy_out, 1);
		wr(8'h00, 32'h81);
		sc(2);
		chk({healthy_out, pending_out}, 2'b00);
		wr(8'h00, 32'h8d);
		press(6);
		chk(release_out, 1);
		wr(8'h00, 32'h8c);
		wr(8'h00, 32'h8d);
		sc(3);
		chk({release_out, healthy_out}, 2'b01);
		$display("test count and start done");
		print_verdict;
	end
endmodule // rri_interlock_tb_top
